// >>> rbp_buffer.sv
// Behaviour
// (R1) capture only on rising true-clock crossing
// (R2) fanout low 25-bit, high 14-bit duplicated
// (R3) pair select picks assignment A or B
// (R4) parity lags data; first device checks
// (R5) second device drives parity and error
// (R6) error held low two cycles or reset
// (R7) receivers off, floating inputs tolerated in reset
// (R8) reset clears registers, forces outputs low; the error output is set high instead
// (R9) reset and selects always driven valid
// (R10) reset held low until clock stable
// (R11) reset fully asynchronous to clock
// (R12) outputs stay low until receivers enabled
// (R13) both chip-selects high holds data outputs
// (R14) any chip-select low updates data outputs
// (R15) reset overrides chip-select gating
// (R16) rank select may be tied low
// (R17) parity lag one or two clocks
// (R18) parity out is xor; error when selected
// (R19) control outputs always registered
`timescale 1ns/1ns
`default_nettype none
`include "rbp_consts.svh"
module rbp_buffer #(
  // post-reset edges that the outputs stay low while the receivers wake
  parameter int unsigned RX_SETTLE = `RBP_RX_SETTLE
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // configuration
  input wire logic pair_select_i,
  input wire logic fanout_select_i,
  // controller side
  input wire rbp_pkg::rbp_data_t data_i,
  input wire logic chip_select_data_in_n_i,
  input wire logic chip_select_rank_in_n_i,
  input wire logic clock_enable_in_i,
  input wire logic termination_in_i,
  input wire logic parity_in_i,
  // dram side
  output logic [`RBP_DATA_W-1:0] registered_outputs_o,
  output logic [`RBP_HALF_W-1:0] registered_outputs_b_o,
  output logic [1:0] chip_select_out_n_o,
  output logic [1:0] clock_enable_out_o,
  output logic [1:0] termination_out_o,
  // parity
  output logic parity_out_o,
  output logic parity_error_n_o
);
  import rbp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    // dram-side copies
    rbp_data_t q;
    rbp_half_t qb;
    logic [1:0] cs;
    logic [1:0] cke;
    logic [1:0] odt;
    // parity result and error latch
    logic parity_out;
    logic err_n;
    logic [1:0] err_cnt;
    // words waiting for their late parity bit
    rbp_data_t par_d1;
    rbp_data_t par_d2;
    logic [1:0] sel_d;
    // wake-up counter
    logic [3:0] settle;
  } rbp_state_s;

  rbp_state_s st;
  rbp_state_s next_st;
  rbp_mode_e mode;
  rbp_data_t cover_mask;
  rbp_data_t look_back;
  rbp_data_t covered;
  wire rbp_half_t dup_copy;
  logic settled;
  logic sel_any;
  logic check_due;
  logic par_res;
  logic err_hit;

  ////////////////////////////////////////////////////////////////////////////
  // configuration decode

  assign mode = rbp_mode_e'({fanout_select_i, fanout_select_i & pair_select_i}); // (R2) (R3)

  // covered data bits per pin assignment; bit n holds input n+1
  always_comb begin
    case (mode)
      RBP_ONE_TO_ONE: begin
        cover_mask = `RBP_MASK_ONE; // (R2)
      end
      RBP_PAIR_A: begin
        cover_mask = `RBP_MASK_A; // (R3)
      end
      RBP_PAIR_B: begin
        cover_mask = `RBP_MASK_B; // (R3)
      end
      default: begin
        cover_mask = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // second output copy

  // one lane per duplicated pin; the b copy stays low in 1:1 so unused pins sit quiet
  for (genvar i = 0; i < `RBP_HALF_W; i++) begin : g_dup
    assign dup_copy[i] = data_i[i] & fanout_select_i; // (R2)
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture qualifiers

  always_comb begin
    settled = (st.settle == 4'(RX_SETTLE));
    sel_any = ~(chip_select_data_in_n_i & chip_select_rank_in_n_i); // (R13) (R14)
  end

  ////////////////////////////////////////////////////////////////////////////
  // parity check

  // parity trails its data by one clock with pair select low, two with it high, so look back that far
  always_comb begin
    if (pair_select_i) begin
      look_back = st.par_d2; // (R17)
      check_due = st.sel_d[1];
    end else begin
      look_back = st.par_d1; // (R17)
      check_due = st.sel_d[0];
    end
    covered = look_back & cover_mask; // (R4)
    par_res = (^covered) ^ parity_in_i; // (R18)
    err_hit = check_due & par_res; // (R18)
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st = st;
    // hold outputs low while receivers are still waking; inputs may be junk
    if (!settled) begin
      next_st.settle = st.settle + 4'h1; // (R12) (R7)
    end else begin
      // control copies follow every capture, gated or not
      next_st.cs = {2{chip_select_data_in_n_i}}; // (R19)
      next_st.cke = {2{clock_enable_in_i}}; // (R19)
      next_st.odt = {2{termination_in_i}}; // (R19)

      if (sel_any) begin // (R14)
        next_st.q = data_i;
        next_st.qb = dup_copy; // (R2)
      end // (R13)

      // unselected words are never checked, so keep zeros in their slot
      if (sel_any) begin
        next_st.par_d1 = data_i;
      end else begin
        next_st.par_d1 = '0;
      end
      next_st.par_d2 = st.par_d1;
      next_st.sel_d = {st.sel_d[0], sel_any};

      if (check_due) begin // (R18)
        next_st.parity_out = par_res; // (R5)
      end

      // a fresh error restarts the two-cycle latch
      if (err_hit) begin
        next_st.err_n = 1'b0; // (R6)
        next_st.err_cnt = `RBP_ERR_HOLD;
      end else if (st.err_cnt != 2'h0) begin
        next_st.err_cnt = st.err_cnt - 2'h1;
        next_st.err_n = (st.err_cnt == 2'h1); // (R6)
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // reset needs no clock: outputs drop and the error flag rises at once, even if the clock is dead
  always_ff @(posedge clock_i or negedge rst_n_i) begin // (R1) (R11)
    if (!rst_n_i) begin // (R8) (R15)
      st.q <= '0;
      st.qb <= '0;
      st.cs <= 2'h0;
      st.cke <= 2'h0;
      st.odt <= 2'h0;
      st.parity_out <= 1'b0;
      st.err_n <= 1'b1;
      st.err_cnt <= 2'h0;
      st.par_d1 <= '0;
      st.par_d2 <= '0;
      st.sel_d <= 2'h0;
      st.settle <= 4'h0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each straight from its flop

  // data copies
  assign registered_outputs_o = st.q;
  assign registered_outputs_b_o = st.qb;

  // control copies
  assign chip_select_out_n_o = st.cs;
  assign clock_enable_out_o = st.cke;
  assign termination_out_o = st.odt;

  // parity status
  assign parity_out_o = st.parity_out;
  assign parity_error_n_o = st.err_n;
endmodule : rbp_buffer
`default_nettype wire

// >>> rbp_buffer_test.sv
`timescale 1ns/1ns
`default_nettype none
module rbp_buffer_test;
  logic clock_i = 0, rst_n_i = 1, bad = 0, cke = 0, fan = 0, pair = 0, p, po, err;
  logic [1:0] cs = 2'h3, cso, ckeo, odt;
  logic [24:0] w = 25'h0, d, q;
  logic [13:0] qb;
  int n_fail = 0, check_count = 0, cyc = 0, k = 0, j = 0;
  always #4 clock_i = ~clock_i;
  rbp_ctrl_model pm (.clock_i, .bad_i(bad), .fanout_i(fan), .pair_i(pair), .word_i(w),
    .data_o(d), .parity_o(p));
  rbp_buffer dut (.clock_i, .rst_n_i, .pair_select_i(pair), .fanout_select_i(fan),
    .data_i(d), .chip_select_data_in_n_i(cs[1]), .chip_select_rank_in_n_i(cs[0]),
    .clock_enable_in_i(cke), .termination_in_i(cke), .parity_in_i(p),
    .registered_outputs_o(q), .registered_outputs_b_o(qb), .chip_select_out_n_o(cso),
    .clock_enable_out_o(ckeo), .termination_out_o(odt), .parity_out_o(po), .parity_error_n_o(err));
  task chk(input logic [24:0] s, e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: %h vs %h", $time, s, e);
    end
  endtask : chk
  task final_report;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task xfer(input logic [24:0] v, input logic [1:0] s, input logic [24:0] e);
    @(posedge clock_i) #1 w = v;
    @(posedge clock_i) #1 cs = s;
    cke = ~cke;
    @(posedge clock_i) #1 chk(q, e);
    chk(qb, fan ? e[13:0] : 14'h0);
    chk({cso, ckeo, odt}, {s[1], s[1], cke, cke, cke, cke});
  endtask : xfer
  task scen;
    xfer(25'h1555555, 2'h1, 25'h1555555);
    xfer(25'h0AAAAAA, 2'h2, 25'h0AAAAAA);
    xfer(25'h1FFFFFF, 2'h3, 25'h0AAAAAA);
    xfer(25'h1234567, 2'h0, 25'h1234567);
    chk({err, po}, 2'h2);
    k = 0;
    j = 0;
    bad = 1;
    @(posedge clock_i) #1 bad = 0;
    repeat (6) @(posedge clock_i) #1 begin
      k += !err;
      j += po;
    end
    chk(k, 2);
    chk(j, 1);
  endtask : scen
  task restart(input logic f, input logic pr);
    #2 rst_n_i = 0;
    #1 chk(q, 25'h0);
    chk({err, po, cso, ckeo, odt, qb}, {1'b1, 21'h0});
    fan = f;
    pair = pr;
    @(posedge clock_i) #1 rst_n_i = 1;
    repeat (4) @(posedge clock_i);
    #1 chk(q, 25'h0);
  endtask : restart
  always @(posedge clock_i) if (++cyc == 300) begin n_fail++; final_report; end
  initial begin
    #1 rst_n_i = 0;
    repeat (6) @(posedge clock_i);
    #1 rst_n_i = 1;
    repeat (4) @(posedge clock_i);
    #1 chk(q, 25'h0);
    scen;
    restart(1'b1, 1'b0);
    scen;
    restart(1'b1, 1'b1);
    scen;
    restart(1'b0, 1'b0);
    final_report;
  end
endmodule : rbp_buffer_test
`default_nettype wire

// >>> rbp_consts.svh
`ifndef RBP_CONSTS_SVH
`define RBP_CONSTS_SVH
`define RBP_DATA_W 25
`define RBP_HALF_W 14
`define RBP_ERR_HOLD 2'h2
`define RBP_RX_SETTLE 4'h4
`define RBP_MASK_ONE 25'h1FFFFB6
`define RBP_MASK_A 25'h0003FB6
`define RBP_MASK_B 25'h0001BBF
`endif

// >>> rbp_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module rbp_ctrl_model (
  input wire logic clock_i, bad_i, fanout_i, pair_i,
  input wire logic [24:0] word_i,
  output logic [24:0] data_o = 25'h0,
  output logic parity_o = 1'b0
);
  logic [24:0] wr;
  logic [24:0] old = 25'h0;
  logic [24:0] m;
  logic b;
  always @(posedge clock_i) begin
    wr = word_i;
    b = bad_i;
    m = !fanout_i ? 25'h1FFFFB6 : pair_i ? 25'h0001BBF : 25'h0003FB6;
    #1 parity_o = ^((pair_i ? old : data_o) & m) ^ b;
    old = data_o;
    data_o = wr;
  end
endmodule : rbp_ctrl_model
`default_nettype wire

// >>> rbp_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module rbp_monitor (
  input wire logic clock_i, rst_n_i, fanout_select_i, clock_enable_in_i,
  input wire logic chip_select_data_in_n_i, chip_select_rank_in_n_i,
  input wire logic parity_out_o, parity_error_n_o,
  input wire logic [24:0] data_i, registered_outputs_o,
  input wire logic [1:0] clock_enable_out_o, chip_select_out_n_o
);
  logic [2:0] up;
  wire logic sel = !(chip_select_data_in_n_i && chip_select_rank_in_n_i);
  // edges since release; capture starts once receivers settle
  always_ff @(posedge clock_i or negedge rst_n_i)
    if (!rst_n_i) up <= 3'h0;
    else if (up != 3'h5) up <= up + 3'h1;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_err; $fell(parity_error_n_o); endsequence
  property p_upd; up == 3'h5 && sel && !fanout_select_i
    |=> registered_outputs_o == $past(data_i); endproperty
  a_upd: assert property (p_upd) else $error("upd");
  property p_hold; up == 3'h5 && !sel |=> $stable(registered_outputs_o); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_cke; up == 3'h5 |=> clock_enable_out_o == {2{$past(clock_enable_in_i)}}; endproperty
  a_cke: assert property (p_cke) else $error("cke");
  property p_cso; up == 3'h5 |=> chip_select_out_n_o == {2{$past(chip_select_data_in_n_i)}};
  endproperty
  a_cso: assert property (p_cso) else $error("cso");
  property p_low; up < 3'h4 |=> registered_outputs_o == 25'h0 && clock_enable_out_o == 2'h0;
  endproperty
  a_low: assert property (p_low) else $error("low");
  property p_err; s_err |-> !parity_error_n_o [*2]; endproperty
  a_err: assert property (p_err) else $error("err");
  property p_po; s_err |-> parity_out_o; endproperty
  a_po: assert property (p_po) else $error("po");
  property p_rst; disable iff (1'b0) !rst_n_i |-> registered_outputs_o == 25'h0 && parity_error_n_o;
  endproperty
  a_rst: assert property (p_rst) else $error("rst");
endmodule : rbp_monitor
bind rbp_buffer rbp_monitor u_mon (.*);
`default_nettype wire

// >>> rbp_pkg.sv
`include "rbp_consts.svh"
package rbp_pkg;
  typedef enum logic [1:0] {
    RBP_ONE_TO_ONE = 2'b00,
    RBP_PAIR_A = 2'b10,
    RBP_PAIR_B = 2'b11
  } rbp_mode_e;
  typedef logic [`RBP_DATA_W-1:0] rbp_data_t;
  typedef logic [`RBP_HALF_W-1:0] rbp_half_t;
endpackage : rbp_pkg
